// ---- rtl/ccp_clock_ctrl.sv ----
`default_nettype none
module ccp_clock_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Power management events on this clock
	input wire logic wakeup_i,
	input wire logic low_power_entry_i,
	// Analog and clock mux status, asynchronous
	input wire logic pll_lock_i,
	input wire logic clock_fail_i,
	input wire logic sysclk_switch_ack_i,
	input wire logic display_sel_ack_i,
	input wire logic base_sel_ack_i,
	// Oscillator controls
	output logic int_fast_osc_enable_o,
	output logic ext_fast_xtal_enable_o,
	output logic ext_xtal_range_o,
	output logic int_slow_osc_enable_o,
	output logic ext_slow_xtal_enable_o,
	output logic low_freq_power_trim_o,
	// Clock selection
	output logic [1:0] sysclk_source_sel_o,
	output logic sysclk_switch_req_o,
	output logic [2:0] tick_timer_clock_sel_o,
	output logic display_clock_sel_req_o,
	output logic base_timer_clock_sel_req_o,
	// PLL controls
	output logic pll_ref_sel_o,
	output logic [4:0] pll_pre_divider_o,
	output logic [7:0] pll_multiplier_o,
	output logic [1:0] pll_post_divider_o,
	output logic pll_power_on_o,
	output logic pll_output_enable_o,
	// Interrupt request to the processor
	output logic clock_fail_irq_o
);

	// Byte-lane merge of write data into an old register image.
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Two-flop synchronisers for the asynchronous status inputs.
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {pll_lock_i, clock_fail_i, sysclk_switch_ack_i, display_sel_ack_i,
				base_sel_ack_i};
			sync2_reg <= sync1_reg;
		end
	end
	logic lock_s;
	logic fail_s;
	logic sw_ack_s;
	logic disp_ack_s;
	logic base_ack_s;
	assign {lock_s, fail_s, sw_ack_s, disp_ack_s, base_ack_s} = sync2_reg;

	// Bus decode. A write takes effect on the edge where ack is high.
	logic ack_reg;
	logic req;
	logic wr;
	assign req = wb_cyc_i & wb_stb_i;
	assign wr = req & wb_we_i & ack_reg;

	logic hit_key;
	logic hit_cfg0;
	logic hit_cfg1;
	logic hit_pll;
	assign hit_key = (wb_adr_i == ccp_pkg::OFS_KEY);
	assign hit_cfg0 = (wb_adr_i == ccp_pkg::OFS_CFG0);
	assign hit_cfg1 = (wb_adr_i == ccp_pkg::OFS_CFG1);
	assign hit_pll = (wb_adr_i == ccp_pkg::OFS_PLL);

	// Write key and window countdown.
	logic [7:0] key_reg;
	logic [7:0] win_cnt_reg;
	logic unlocked_reg;
	logic [31:0] key_new;
	logic prot_wr;
	assign key_new = wb_merge({24'h000000, key_reg}, wb_dat_i, wb_sel_i);
	assign prot_wr = wr & unlocked_reg & (hit_cfg0 | hit_cfg1 | hit_pll);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_reg <= 8'h00;
			win_cnt_reg <= 8'h00;
			unlocked_reg <= 1'b0;
		end else if (wr && hit_key) begin
			key_reg <= key_new[7:0];
			// A key below the threshold shuts the window at once.
			unlocked_reg <= (key_new[7:0] >= ccp_pkg::KEY_MIN);
			win_cnt_reg <= key_new[7:0];
		end else if (prot_wr) begin
			// Each accepted protected write restarts the window.
			win_cnt_reg <= key_reg;
		end else if (unlocked_reg) begin
			if (win_cnt_reg <= 8'h01) begin
				unlocked_reg <= 1'b0;
				win_cnt_reg <= 8'h00;
			end else begin
				win_cnt_reg <= win_cnt_reg - 8'h01;
			end
		end
	end

	// System clock switch handshake with the clock mux.
	ccp_pkg::ccp_sw_state_t sw_state_reg;
	logic [31:0] cfg0_img;
	logic [31:0] cfg0_new;
	logic sw_bit;
	logic sysclk_ext;
	logic pll_is_sysclk;
	// The switch bit shows the mux's confirmed state, not the last write.
	assign sw_bit = (sw_state_reg == ccp_pkg::SW_TARGET) ||
		(sw_state_reg == ccp_pkg::SW_TO_FAST_OSC);
	assign sysclk_ext = (sw_state_reg == ccp_pkg::SW_TARGET) &&
		(sysclk_source_sel_o != ccp_pkg::SRC_SLOW_OSC);
	assign pll_is_sysclk = sw_bit && (sysclk_source_sel_o == ccp_pkg::SRC_PLL);
	assign cfg0_new = wb_merge(cfg0_img, wb_dat_i, wb_sel_i);

	logic fail_event;
	logic fail_prev_reg;
	assign fail_event = fail_s & ~fail_prev_reg & sysclk_ext;

	always_ff @(posedge clk_i) begin
		if (rst_i || wakeup_i) begin
			sw_state_reg <= ccp_pkg::SW_FAST_OSC;
		end else begin
			case (sw_state_reg)
				ccp_pkg::SW_FAST_OSC: begin
					if (prot_wr && hit_cfg0 && cfg0_new[ccp_pkg::CFG0_SW]) begin
						sw_state_reg <= ccp_pkg::SW_TO_TARGET;
					end
				end
				ccp_pkg::SW_TO_TARGET: begin
					if (sw_ack_s) begin
						sw_state_reg <= ccp_pkg::SW_TARGET;
					end
				end
				ccp_pkg::SW_TARGET: begin
					if (fail_event) begin
						sw_state_reg <= ccp_pkg::SW_TO_FAST_OSC;
					end else if (prot_wr && hit_cfg0 && !cfg0_new[ccp_pkg::CFG0_SW]) begin
						sw_state_reg <= ccp_pkg::SW_TO_FAST_OSC;
					end
				end
				ccp_pkg::SW_TO_FAST_OSC: begin
					if (!sw_ack_s) begin
						sw_state_reg <= ccp_pkg::SW_FAST_OSC;
					end
				end
				default: sw_state_reg <= ccp_pkg::SW_FAST_OSC;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || wakeup_i) begin
			sysclk_switch_req_o <= 1'b0;
		end else begin
			sysclk_switch_req_o <= (sw_state_reg == ccp_pkg::SW_TO_TARGET) ||
				(sw_state_reg == ccp_pkg::SW_TARGET && !fail_event);
		end
	end

	// System clock config fields.
	logic clock_fail_irq_enable_reg;
	assign cfg0_img = {16'h0000, clock_fail_irq_enable_reg, 3'h0, low_freq_power_trim_o, 1'b0,
		sysclk_source_sel_o, sw_bit, int_fast_osc_enable_o, ext_fast_xtal_enable_o,
		ext_xtal_range_o, 2'h0, int_slow_osc_enable_o, ext_slow_xtal_enable_o};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_fail_irq_enable_reg <= 1'b0;
			low_freq_power_trim_o <= 1'b0;
			sysclk_source_sel_o <= ccp_pkg::SRC_SLOW_OSC;
			ext_xtal_range_o <= 1'b0;
			int_slow_osc_enable_o <= 1'b0;
			ext_slow_xtal_enable_o <= 1'b0;
		end else if (prot_wr && hit_cfg0) begin
			clock_fail_irq_enable_reg <= cfg0_new[ccp_pkg::CFG0_IRQEN];
			low_freq_power_trim_o <= cfg0_new[ccp_pkg::CFG0_TRIM];
			sysclk_source_sel_o <= cfg0_new[ccp_pkg::CFG0_SEL_LSB +: 2];
			ext_xtal_range_o <= cfg0_new[ccp_pkg::CFG0_RANGE];
			int_slow_osc_enable_o <= cfg0_new[ccp_pkg::CFG0_SOSC];
			ext_slow_xtal_enable_o <= cfg0_new[ccp_pkg::CFG0_SXT];
		end
	end

	// Oscillator enables that reset and wake-up also force.
	always_ff @(posedge clk_i) begin
		if (rst_i || wakeup_i) begin
			int_fast_osc_enable_o <= ccp_pkg::FOSC_RST;
			ext_fast_xtal_enable_o <= 1'b0;
		end else if (prot_wr && hit_cfg0) begin
			// Stopping the oscillator that clocks the system would hang it.
			if (sw_bit) begin
				int_fast_osc_enable_o <= cfg0_new[ccp_pkg::CFG0_FOSC];
			end
			ext_fast_xtal_enable_o <= cfg0_new[ccp_pkg::CFG0_FXT];
		end
	end

	// Peripheral clock select.
	logic [31:0] cfg1_img;
	logic [31:0] cfg1_new;
	assign cfg1_img = {24'h000000, tick_timer_clock_sel_o, 3'h0, disp_ack_s, base_ack_s};
	assign cfg1_new = wb_merge(cfg1_img, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_timer_clock_sel_o <= 3'h0;
			display_clock_sel_req_o <= 1'b0;
			base_timer_clock_sel_req_o <= 1'b0;
		end else if (prot_wr && hit_cfg1) begin
			tick_timer_clock_sel_o <= cfg1_new[ccp_pkg::CFG1_TICK_LSB +: 3];
			display_clock_sel_req_o <= cfg1_new[ccp_pkg::CFG1_DISP];
			base_timer_clock_sel_req_o <= cfg1_new[ccp_pkg::CFG1_BASE];
		end
	end

	// PLL config.
	logic [31:0] pll_img;
	logic [31:0] pll_new;
	assign pll_img = {8'h00, pll_ref_sel_o, 2'h0, pll_pre_divider_o, pll_multiplier_o,
		pll_power_on_o, pll_output_enable_o, 4'h0, pll_post_divider_o};
	assign pll_new = wb_merge(pll_img, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_ref_sel_o <= 1'b0;
			pll_pre_divider_o <= 5'h00;
			pll_multiplier_o <= 8'h00;
			pll_post_divider_o <= 2'h0;
		end else if (prot_wr && hit_pll) begin
			pll_pre_divider_o <= pll_new[ccp_pkg::PLL_PRE_LSB +: 5];
			pll_multiplier_o <= pll_new[ccp_pkg::PLL_MUL_LSB +: 8];
			if (!pll_power_on_o) begin
				pll_ref_sel_o <= pll_new[ccp_pkg::PLL_REF];
				pll_post_divider_o <= pll_new[ccp_pkg::PLL_POST_LSB +: 2];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_power_on_o <= 1'b0;
		end else if (pll_is_sysclk) begin
			// The running system clock source must keep its PLL powered.
			if (prot_wr && hit_pll) begin
				pll_power_on_o <= 1'b1;
			end
		end else if (low_power_entry_i) begin
			pll_power_on_o <= 1'b0;
		end else if (prot_wr && hit_pll) begin
			pll_power_on_o <= pll_new[ccp_pkg::PLL_PWR];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_output_enable_o <= 1'b0;
		end else if (prot_wr && hit_pll && !pll_is_sysclk) begin
			pll_output_enable_o <= pll_new[ccp_pkg::PLL_OEN];
		end
	end

	// Status: live lock, sticky loss of lock, sticky clock failure.
	logic lock_prev_reg;
	logic lost_reg;
	logic fail_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_prev_reg <= 1'b0;
			fail_prev_reg <= 1'b0;
			lost_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else begin
			lock_prev_reg <= lock_s;
			fail_prev_reg <= fail_s;
			if (lock_prev_reg && !lock_s && pll_power_on_o) begin
				lost_reg <= 1'b1;
			end
			if (fail_event) begin
				fail_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_fail_irq_o <= 1'b0;
		end else begin
			clock_fail_irq_o <= fail_reg & clock_fail_irq_enable_reg;
		end
	end

	// Read mux and acknowledge; unmapped addresses read zero.
	logic [31:0] rd_data;
	always_comb begin
		case (wb_adr_i)
			ccp_pkg::OFS_KEY: rd_data = {24'h000000, key_reg};
			ccp_pkg::OFS_CFG0: rd_data = cfg0_img;
			ccp_pkg::OFS_CFG1: rd_data = cfg1_img;
			ccp_pkg::OFS_PLL: rd_data = pll_img;
			ccp_pkg::OFS_STS: rd_data = {29'h00000000, lock_s, lost_reg, fail_reg};
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg) begin
				wb_dat_o <= rd_data;
			end
		end
	end
	assign wb_ack_o = ack_reg;

endmodule // ccp_clock_ctrl
`default_nettype wire

// ---- rtl/ccp_pkg.sv ----
`default_nettype none
package ccp_pkg;
	// Register byte addresses on the bus.
	localparam logic [7:0] OFS_KEY = 8'h00;
	localparam logic [7:0] OFS_CFG0 = 8'h04;
	localparam logic [7:0] OFS_CFG1 = 8'h08;
	localparam logic [7:0] OFS_PLL = 8'h0c;
	localparam logic [7:0] OFS_STS = 8'h10;

	// Write key.
	localparam logic [7:0] KEY_MIN = 8'h40;
	localparam int KEY_LSB = 0;

	// System clock config fields.
	localparam int CFG0_IRQEN = 15;
	localparam int CFG0_TRIM = 11;
	localparam int CFG0_SEL_LSB = 8;
	localparam int CFG0_SW = 7;
	localparam int CFG0_FOSC = 6;
	localparam int CFG0_FXT = 5;
	localparam int CFG0_RANGE = 4;
	localparam int CFG0_SOSC = 1;
	localparam int CFG0_SXT = 0;

	// Peripheral clock select fields.
	localparam int CFG1_TICK_LSB = 5;
	localparam int CFG1_DISP = 1;
	localparam int CFG1_BASE = 0;

	// PLL config fields.
	localparam int PLL_REF = 23;
	localparam int PLL_PRE_LSB = 16;
	localparam int PLL_MUL_LSB = 8;
	localparam int PLL_PWR = 7;
	localparam int PLL_OEN = 6;
	localparam int PLL_POST_LSB = 0;

	// Status fields.
	localparam int STS_LOCK = 2;
	localparam int STS_LOST = 1;
	localparam int STS_FAIL = 0;

	// System clock source codes.
	localparam logic [1:0] SRC_SLOW_OSC = 2'h0;
	localparam logic [1:0] SRC_FAST_XTAL = 2'h1;
	localparam logic [1:0] SRC_PLL = 2'h2;
	localparam logic [1:0] SRC_SLOW_XTAL = 2'h3;

	// Reset values of fields that are not zero.
	localparam logic FOSC_RST = 1'b1;

	// System clock switch handshake, Gray coded along its cycle.
	typedef enum logic [1:0] {
		SW_FAST_OSC = 2'b00,
		SW_TO_TARGET = 2'b01,
		SW_TARGET = 2'b11,
		SW_TO_FAST_OSC = 2'b10
	} ccp_sw_state_t;
endpackage
`default_nettype wire

// ---- tb/ccp_clock_ctrl_assertions.sv ----
`default_nettype none
module ccp_clock_ctrl_assertions (
	// Bus and events
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic wakeup_i,
	input wire logic low_power_entry_i,
	input wire logic clock_fail_i,
	input wire logic sysclk_switch_ack_i,
	// Controls
	input wire logic int_fast_osc_enable_o,
	input wire logic ext_fast_xtal_enable_o,
	input wire logic [1:0] sysclk_source_sel_o,
	input wire logic sysclk_switch_req_o,
	input wire logic [2:0] tick_timer_clock_sel_o,
	input wire logic [7:0] pll_multiplier_o,
	input wire logic pll_ref_sel_o,
	input wire logic [1:0] pll_post_divider_o,
	input wire logic pll_power_on_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_reset_image: assert property (disable iff (1'b0) rst_i |=>
		int_fast_osc_enable_o && !ext_fast_xtal_enable_o && !sysclk_switch_req_o)
		else $error("bad reset image");
	chk_wake_image: assert property (wakeup_i |=>
		int_fast_osc_enable_o && !ext_fast_xtal_enable_o && !sysclk_switch_req_o)
		else $error("bad wake image");
	chk_pll_sleep: assert property (low_power_entry_i &&
		sysclk_source_sel_o != ccp_pkg::SRC_PLL |=> !pll_power_on_o)
		else $error("pll power kept");
	chk_cfg_by_write: assert property ($changed(pll_multiplier_o) ||
		$changed(tick_timer_clock_sel_o) |-> $past(wb_ack_o && wb_we_i))
		else $error("config changed without write");
	chk_pll_fields_hold: assert property ($past(pll_power_on_o) |->
		$stable(pll_ref_sel_o) && $stable(pll_post_divider_o))
		else $error("pll field written while on");
	chk_req_after_write: assert property ($rose(sysclk_switch_req_o) |->
		$past(wb_ack_o, 1) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
		else $error("switch request without write");
	chk_fail_drop: assert property (sysclk_switch_req_o &&
		$past(sysclk_switch_ack_i, 6) && $rose(clock_fail_i) &&
		sysclk_source_sel_o != ccp_pkg::SRC_SLOW_OSC |-> ##[1:6] !sysclk_switch_req_o)
		else $error("no fallback on failure");
endmodule // ccp_clock_ctrl_assertions
bind ccp_clock_ctrl ccp_clock_ctrl_assertions u_ccp_clock_ctrl_assertions (.*);
`default_nettype wire

// ---- tb/ccp_clock_ctrl_tb_top.sv ----
`default_nettype none
module ccp_clock_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic wakeup_i = 1'b0, low_power_entry_i = 1'b0, pll_lock_i = 1'b0, clock_fail_i = 1'b0;
	logic sysclk_switch_ack_i = 1'b0, display_sel_ack_i = 1'b0, base_sel_ack_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, int_fast_osc_enable_o, ext_fast_xtal_enable_o, ext_xtal_range_o;
	logic int_slow_osc_enable_o, ext_slow_xtal_enable_o, low_freq_power_trim_o;
	logic [1:0] sysclk_source_sel_o, pll_post_divider_o;
	logic sysclk_switch_req_o, display_clock_sel_req_o, base_timer_clock_sel_req_o;
	logic [2:0] tick_timer_clock_sel_o;
	logic pll_ref_sel_o, pll_power_on_o, pll_output_enable_o, clock_fail_irq_o;
	logic [4:0] pll_pre_divider_o;
	logic [7:0] pll_multiplier_o, mul;
	logic [31:0] exp_q[$];
	logic [7:0] adr_q[$];
	logic [31:0] rnd = 32'haa80;
	int err_count = 0, samples_checked = 0;

	ccp_clock_ctrl u_ccp_clock_ctrl (.*);

	always #25 clk_i = ~clk_i;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] pv(input logic r, input logic [7:0] lo);
		return {8'h00, r, 2'b00, 5'h08, mul, lo};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		samples_checked++;
		if (seen !== ex) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// The request stands until ack is sampled high, then drops for a cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		wb(1'b0, a, 32'h0);
	endtask

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			chk($sformatf("reg %h", adr_q.pop_front()), wb_dat_o, exp_q.pop_front());
		end
	end

	initial begin
		#200000;
		err_count++;
		give_verdict();
	end

	initial begin
		tick(16);
		rst_i <= 1'b0;
		rd(ccp_pkg::OFS_KEY, 32'h0);
		rd(ccp_pkg::OFS_CFG0, 32'h40);
		rd(ccp_pkg::OFS_CFG1, 32'h0);
		rd(ccp_pkg::OFS_STS, 32'h0);
		rd(8'h14, 32'h0);
		wb(1'b1, ccp_pkg::OFS_PLL, 32'h0081_ffc3);
		rd(ccp_pkg::OFS_PLL, 32'h0);
		wb(1'b1, ccp_pkg::OFS_KEY, 32'h3f);
		wb(1'b1, ccp_pkg::OFS_CFG1, 32'he0);
		rd(ccp_pkg::OFS_CFG1, 32'h0);
		rd(ccp_pkg::OFS_KEY, 32'h3f);
		wb(1'b1, ccp_pkg::OFS_KEY, 32'hff);
		wb(1'b1, ccp_pkg::OFS_CFG0, 32'hffff_ff3f);
		rd(ccp_pkg::OFS_CFG0, 32'h8b73);
		chk("osc", 32'({low_freq_power_trim_o, sysclk_source_sel_o, ext_fast_xtal_enable_o,
			ext_xtal_range_o, int_slow_osc_enable_o, ext_slow_xtal_enable_o}), 32'h7f);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, ccp_pkg::OFS_CFG1, 32'(i) << 5);
			chk("tick", 32'(tick_timer_clock_sel_o), 32'(i));
		end
		wb(1'b1, ccp_pkg::OFS_CFG1, 32'h3);
		chk("sel req", 32'({display_clock_sel_req_o, base_timer_clock_sel_req_o}), 32'h3);
		rd(ccp_pkg::OFS_CFG1, 32'h0);
		display_sel_ack_i <= 1'b1;
		base_sel_ack_i <= 1'b1;
		tick(4);
		rd(ccp_pkg::OFS_CFG1, 32'h3);
		rnd = lfsr(lfsr(rnd));
		mul = 8'(2 + rnd % 191);
		wb(1'b1, ccp_pkg::OFS_PLL, pv(1'b1, 8'h42));
		rd(ccp_pkg::OFS_PLL, pv(1'b1, 8'h42));
		wb(1'b1, ccp_pkg::OFS_PLL, pv(1'b1, 8'hc2));
		wb(1'b1, ccp_pkg::OFS_PLL, pv(1'b0, 8'hc3));
		rd(ccp_pkg::OFS_PLL, pv(1'b1, 8'hc2));
		// Lane 0 is masked off, so power, output enable and post-divider must keep their values.
		wb_sel_i <= 4'he;
		wb(1'b1, ccp_pkg::OFS_PLL, pv(1'b1, 8'h00));
		wb_sel_i <= 4'hf;
		rd(ccp_pkg::OFS_PLL, pv(1'b1, 8'hc2));
		pll_lock_i <= 1'b1;
		tick(4);
		rd(ccp_pkg::OFS_STS, 32'h4);
		pll_lock_i <= 1'b0;
		tick(4);
		rd(ccp_pkg::OFS_STS, 32'h2);
		wb(1'b1, ccp_pkg::OFS_KEY, 32'h40);
		tick(70);
		wb(1'b1, ccp_pkg::OFS_CFG1, 32'h80);
		chk("tick", 32'(tick_timer_clock_sel_o), 32'h0);
		wb(1'b1, ccp_pkg::OFS_KEY, 32'hff);
		wb(1'b1, ccp_pkg::OFS_CFG0, 32'h82f3);
		rd(ccp_pkg::OFS_CFG0, 32'h8273);
		for (int i = 0; i < 8 && sysclk_switch_req_o !== 1'b1; i++) tick(1);
		chk("req", 32'(sysclk_switch_req_o), 32'h1);
		sysclk_switch_ack_i <= 1'b1;
		tick(5);
		rd(ccp_pkg::OFS_CFG0, 32'h82f3);
		wb(1'b1, ccp_pkg::OFS_PLL, pv(1'b1, 8'h02));
		rd(ccp_pkg::OFS_PLL, pv(1'b1, 8'hc2));
		low_power_entry_i <= 1'b1;
		tick(1);
		low_power_entry_i <= 1'b0;
		tick(2);
		chk("pll on", 32'(pll_power_on_o), 32'h1);
		wb(1'b1, ccp_pkg::OFS_CFG0, 32'h82b3);
		rd(ccp_pkg::OFS_CFG0, 32'h82b3);
		wb(1'b1, ccp_pkg::OFS_CFG0, 32'h82f3);
		clock_fail_i <= 1'b1;
		tick(6);
		chk("req", 32'(sysclk_switch_req_o), 32'h0);
		chk("irq", 32'(clock_fail_irq_o), 32'h1);
		rd(ccp_pkg::OFS_STS, 32'h3);
		sysclk_switch_ack_i <= 1'b0;
		clock_fail_i <= 1'b0;
		tick(4);
		wb(1'b1, ccp_pkg::OFS_CFG0, 32'h0173);
		tick(2);
		chk("irq", 32'(clock_fail_irq_o), 32'h0);
		low_power_entry_i <= 1'b1;
		tick(1);
		low_power_entry_i <= 1'b0;
		tick(2);
		chk("pll on", 32'(pll_power_on_o), 32'h0);
		wakeup_i <= 1'b1;
		tick(1);
		wakeup_i <= 1'b0;
		tick(2);
		chk("wake", 32'({int_fast_osc_enable_o, ext_fast_xtal_enable_o,
			sysclk_switch_req_o}), 32'h4);
		give_verdict();
	end
endmodule // ccp_clock_ctrl_tb_top
`default_nettype wire
